// *** rtl/radio_tx_pkg.sv ***
// Shared constants and types for the transmit framer and receive enable control.
// Assumes a 40 MHz system clock and a separate symbol-rate link clock.
package radio_tx_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_MHZ = 40;
	localparam int TURNAROUND_US = 192;
	localparam int TURNAROUND_CYC = TURNAROUND_US * SYS_CLK_MHZ;
	localparam int VALID_SYMBOLS = 8;
	localparam int CCA_DELAY_CYC = 4;
	// ----------------------------------------
	// Values and positions
	// ----------------------------------------
	localparam logic [7:0] SFD_PIN_CFG = 8'h2A;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] RX_MASK_RESET = 16'h0000;
	localparam logic [6:0] TX_POWER_RESET = 7'h32;
	localparam int RX_ON_BIT = 15;
	localparam int TX_SET_BIT = 14;
	localparam int MASK_STROBE_BIT = 13;
	localparam logic [6:0] LEN_MASK = 7'h7F;

	typedef enum logic [2:0] {
		MASK_WRITE,
		MASK_BIT_SET,
		MASK_BIT_CLEAR,
		MASK_AND,
		MASK_OR
	} mask_op_t;
endpackage

// *** rtl/crc16_unit.sv ***
// Bytewise 16-bit frame check sequence, polynomial x^16+x^12+x^5+1, LSB first.
// Assumes one byte per i_en pulse on the link clock.
module crc16_unit (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_clr,
	// Data
	input wire logic i_en,
	input wire logic [7:0] i_byte,
	output logic [15:0] o_crc
);
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int k = 0; k < 8; k++) begin
			// Reflected form of the same polynomial
			if (r[0] ^ d[k])
				r = (r >> 1) ^ 16'h8408;
			else
				r = r >> 1;
		end
		return r;
	endfunction

	always_ff @(posedge i_clk) begin
		if (i_clr)
			o_crc <= radio_tx_pkg::CRC_INIT;
		else if (i_en)
			o_crc <= crc_step(o_crc, i_byte);
	end
endmodule // crc16_unit

// *** rtl/sync2.sv ***
// Two-flop level synchroniser into the destination clock.
// Assumes input is a level held long enough to be seen.
module sync2 (
	input wire logic i_clk,
	input wire logic i_d,
	output logic o_q
);
	logic meta;
	always_ff @(posedge i_clk) begin
		meta <= i_d;
		o_q <= meta;
	end
endmodule // sync2

// *** rtl/radio_tx_framing_rx_enable_ctrl.sv ***
// Transmit framing on the link clock, receive enable mask and clear channel
// logic on the system clock. Assumes the TX FIFO sits outside and answers a
// one-byte fetch request on the link clock with data valid in the next cycle.
//
// Behaviour
// - After delimiter, send length then length bytes
// - Checksum built internally and appended, never stored
// - Checksum off: last two bytes come from FIFO
// - Start event after delimiter fully sent
// - Done event only after complete frame
// - Delimiter signal on pin when config 0x2A
// - Strength valid after 8 symbols receiver enabled
// - Clear channel from strength versus threshold
// - Live and sampled clear channel flags
// - Clear flag updates four cycles after valid
// - Seven-bit output power register drives transmitter
// - Fetching continues while FIFO still being written
// - Test bit selects non-standard modulation
// - Receive-on sets bit 15, aborts activity
// - Transmit-on sets bit 14 when option set
// - Nonzero mask enables receiver without abort
// - Radio-off clears mask, aborts, goes idle
// - Zero mask idles after activity finishes
// - Mask strobes set or clear bit 13
// - Preamble starts 192 us after transmit strobe
// - Checksum covers frame body, not length
// - Checksum polynomial x16+x12+x5+1
module radio_tx_framing_rx_enable_ctrl #(
	parameter int TURNAROUND_CYC = radio_tx_pkg::TURNAROUND_CYC
) (
	// System clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Link clock and its reset
	input wire logic i_link_clk,
	input wire logic i_link_rst,
	// Strobes (one-cycle pulses, system clock)
	input wire logic i_strobe_receive_on,
	input wire logic i_strobe_radio_off,
	input wire logic i_strobe_transmit_on,
	input wire logic i_strobe_transmit_if_clear,
	input wire logic i_strobe_sample_clear_channel,
	input wire logic i_strobe_rx_mask_bit_set,
	input wire logic i_strobe_rx_mask_bit_clear,
	// Mask instruction
	input wire logic i_mask_instr,
	input wire radio_tx_pkg::mask_op_t i_mask_op,
	input wire logic [15:0] i_mask_data,
	// Configuration
	input wire logic i_auto_checksum_en,
	input wire logic i_rx_mask_set_on_transmit,
	input wire logic i_alt_modulation_sel,
	input wire logic [6:0] i_tx_power_level,
	input wire logic i_tx_power_wr,
	input wire logic [7:0] i_gpio_cfg,
	input wire logic [7:0] i_cca_threshold,
	input wire logic [1:0] i_cca_mode,
	// Signal strength samples (system clock)
	input wire logic i_rssi_sample,
	input wire logic [7:0] i_rssi,
	input wire logic i_symbol_tick,
	// TX FIFO fetch (link clock)
	output logic o_fifo_rd,
	input wire logic [7:0] i_fifo_data,
	// Modulator side (link clock)
	output logic o_mod_valid,
	output logic [7:0] o_mod_byte,
	output logic o_mod_alt,
	input wire logic i_sfd_sent,
	// Status
	output logic [15:0] o_rx_enable_mask,
	output logic o_rx_on,
	output logic o_tx_active,
	output logic o_preamble_start,
	output logic o_signal_strength_valid,
	output logic o_cca,
	output logic o_sampled_cca,
	output logic o_sfd_evt,
	output logic o_tx_frame_complete_evt,
	output logic o_gpio_sfd,
	output logic [6:0] o_tx_power_level
);
	// ----------------------------------------
	// Radio state (system clock)
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_RX_CAL, ST_RX, ST_TX_CAL, ST_TX} radio_state_t;
	radio_state_t state;
	logic [15:0] turn_cnt;
	logic tx_go;
	logic tx_done_sys;
	logic tx_start_req;
	logic abort_sys;
	logic [3:0] sym_cnt;

	assign tx_go = i_strobe_transmit_on
		| (i_strobe_transmit_if_clear & o_cca);
	assign abort_sys = i_strobe_receive_on | i_strobe_radio_off | tx_go;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= ST_IDLE;
			turn_cnt <= 16'h0000;
		end else if (i_strobe_radio_off) begin
			state <= ST_IDLE;
		end else if (tx_go) begin
			state <= ST_TX_CAL;
			turn_cnt <= 16'h0000;
		end else if (i_strobe_receive_on) begin
			state <= ST_RX_CAL;
			turn_cnt <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					// Soft enable never aborts activity
					if (o_rx_on) begin
						state <= ST_RX_CAL;
						turn_cnt <= 16'h0000;
					end
				end
				ST_RX_CAL, ST_TX_CAL: begin
					if (turn_cnt == 16'(TURNAROUND_CYC - 1))
						state <= (state == ST_TX_CAL) ? ST_TX : ST_RX;
					else
						turn_cnt <= turn_cnt + 16'h0001;
				end
				ST_RX: begin
					if (!o_rx_on)
						state <= ST_IDLE;
				end
				ST_TX: begin
					if (tx_done_sys) begin
						turn_cnt <= 16'h0000;
						state <= o_rx_on ? ST_RX_CAL : ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign o_tx_active = (state == ST_TX);
	assign tx_start_req = (state == ST_TX_CAL) && (turn_cnt == 16'(TURNAROUND_CYC - 1));
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_preamble_start <= 1'b0;
		else
			o_preamble_start <= tx_start_req;
	end

	// ----------------------------------------
	// Receive enable mask
	// ----------------------------------------
	function automatic logic [15:0] mask_apply(input logic [15:0] cur,
			input radio_tx_pkg::mask_op_t op, input logic [15:0] d);
		case (op)
			radio_tx_pkg::MASK_WRITE: return d;
			radio_tx_pkg::MASK_BIT_SET: return cur | (16'h0001 << d[3:0]);
			radio_tx_pkg::MASK_BIT_CLEAR: return cur & ~(16'h0001 << d[3:0]);
			radio_tx_pkg::MASK_AND: return cur & d;
			radio_tx_pkg::MASK_OR: return cur | d;
			default: return cur;
		endcase
	endfunction

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rx_enable_mask <= radio_tx_pkg::RX_MASK_RESET;
		end else if (i_strobe_radio_off) begin
			o_rx_enable_mask <= 16'h0000;
		end else begin
			logic [15:0] m;
			m = o_rx_enable_mask;
			if (i_mask_instr)
				m = mask_apply(m, i_mask_op, i_mask_data);
			if (i_strobe_rx_mask_bit_set)
				m[radio_tx_pkg::MASK_STROBE_BIT] = 1'b1;
			if (i_strobe_rx_mask_bit_clear)
				m[radio_tx_pkg::MASK_STROBE_BIT] = 1'b0;
			if (i_strobe_receive_on)
				m[radio_tx_pkg::RX_ON_BIT] = 1'b1;
			if (i_strobe_transmit_on && i_rx_mask_set_on_transmit)
				m[radio_tx_pkg::TX_SET_BIT] = 1'b1;
			o_rx_enable_mask <= m;
		end
	end

	assign o_rx_on = |o_rx_enable_mask;

	// ----------------------------------------
	// Signal strength valid and clear channel
	// ----------------------------------------
	logic [2:0] cca_dly;
	logic cca_live_next;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || state != ST_RX) begin
			sym_cnt <= 4'h0;
			o_signal_strength_valid <= 1'b0;
		end else if (i_symbol_tick && !o_signal_strength_valid) begin
			if (sym_cnt == 4'(radio_tx_pkg::VALID_SYMBOLS - 1))
				o_signal_strength_valid <= 1'b1;
			sym_cnt <= sym_cnt + 4'h1;
		end
	end

	// Mode 0 always clear; 1 below threshold; 2 and 3 reserved as below threshold
	always_comb begin
		case (i_cca_mode)
			2'b00: cca_live_next = 1'b1;
			default: cca_live_next = (i_rssi < i_cca_threshold);
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !o_signal_strength_valid) begin
			cca_dly <= 3'h0;
			o_cca <= 1'b0;
		end else begin
			// Hold off first update four cycles past valid
			if (cca_dly != 3'(radio_tx_pkg::CCA_DELAY_CYC))
				cca_dly <= cca_dly + 3'h1;
			if (cca_dly == 3'(radio_tx_pkg::CCA_DELAY_CYC - 1)
					|| (cca_dly == 3'(radio_tx_pkg::CCA_DELAY_CYC) && i_rssi_sample))
				o_cca <= cca_live_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_sampled_cca <= 1'b0;
		else if (i_strobe_sample_clear_channel || i_strobe_transmit_if_clear)
			o_sampled_cca <= o_cca;
	end

	// ----------------------------------------
	// Output power
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_tx_power_level <= radio_tx_pkg::TX_POWER_RESET;
		else if (i_tx_power_wr)
			o_tx_power_level <= i_tx_power_level & radio_tx_pkg::LEN_MASK;
	end

	// ----------------------------------------
	// Domain crossing: run level to link, events back by toggle, delimiter level back as a level
	// ----------------------------------------
	logic tx_run;
	logic tx_run_link;
	logic done_tgl;
	logic sfd_tgl;
	logic done_tgl_s;
	logic sfd_tgl_s;
	logic done_tgl_d;
	logic sfd_tgl_d;
	logic sfd_level;
	logic sfd_level_s;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			tx_run <= 1'b0;
		else if (abort_sys || tx_done_sys)
			tx_run <= 1'b0;
		else if (tx_start_req)
			tx_run <= 1'b1;
	end

	sync2 u_run_sync (.i_clk(i_link_clk), .i_d(tx_run), .o_q(tx_run_link));
	sync2 u_done_sync (.i_clk(i_sys_clk), .i_d(done_tgl), .o_q(done_tgl_s));
	sync2 u_sfd_sync (.i_clk(i_sys_clk), .i_d(sfd_tgl), .o_q(sfd_tgl_s));
	sync2 u_sfdl_sync (.i_clk(i_sys_clk), .i_d(sfd_level), .o_q(sfd_level_s));

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			done_tgl_d <= 1'b0;
			sfd_tgl_d <= 1'b0;
			o_sfd_evt <= 1'b0;
			o_tx_frame_complete_evt <= 1'b0;
			o_gpio_sfd <= 1'b0;
		end else begin
			done_tgl_d <= done_tgl_s;
			sfd_tgl_d <= sfd_tgl_s;
			o_sfd_evt <= sfd_tgl_s ^ sfd_tgl_d;
			o_tx_frame_complete_evt <= (done_tgl_s ^ done_tgl_d) && tx_run;
			o_gpio_sfd <= (i_gpio_cfg == radio_tx_pkg::SFD_PIN_CFG) && sfd_level_s;
		end
	end
	assign tx_done_sys = (done_tgl_s ^ done_tgl_d);

	// ----------------------------------------
	// Link-side framer
	// ----------------------------------------
	typedef enum {LK_WAIT_SFD, LK_LEN, LK_BODY, LK_FCS_LO, LK_FCS_HI, LK_DONE} link_state_t;
	link_state_t lstate;
	logic [6:0] remain;
	logic fetch_pend;
	logic auto_crc;
	logic [15:0] crc;
	logic crc_en;
	logic auto_link;
	logic alt_link;

	sync2 u_auto_sync (.i_clk(i_link_clk), .i_d(i_auto_checksum_en), .o_q(auto_link));
	sync2 u_alt_sync (.i_clk(i_link_clk), .i_d(i_alt_modulation_sel), .o_q(alt_link));

	// Frame body only; length byte stays outside the checksum
	assign crc_en = fetch_pend && (lstate == LK_BODY) && auto_crc;
	crc16_unit u_crc (
		.i_clk(i_link_clk),
		.i_clr(lstate == LK_WAIT_SFD),
		.i_en(crc_en),
		.i_byte(i_fifo_data),
		.o_crc(crc)
	);

	always_ff @(posedge i_link_clk) begin
		if (i_link_rst || !tx_run_link) begin
			// Aborts land here through the run level
			lstate <= LK_WAIT_SFD;
			remain <= 7'h00;
			fetch_pend <= 1'b0;
			auto_crc <= 1'b0;
			o_fifo_rd <= 1'b0;
			o_mod_valid <= 1'b0;
			o_mod_byte <= 8'h00;
			sfd_level <= 1'b0;
		end else begin
			o_fifo_rd <= 1'b0;
			o_mod_valid <= 1'b0;
			fetch_pend <= o_fifo_rd;
			case (lstate)
				LK_WAIT_SFD: begin
					if (i_sfd_sent) begin
						auto_crc <= auto_link;
						sfd_level <= 1'b1;
						o_fifo_rd <= 1'b1;
						lstate <= LK_LEN;
					end
				end
				LK_LEN: begin
					if (fetch_pend) begin
						o_mod_valid <= 1'b1;
						o_mod_byte <= i_fifo_data;
						// Checksum bytes counted in length; not fetched when auto checksum is on
						remain <= (i_fifo_data[6:0] & radio_tx_pkg::LEN_MASK)
							- (auto_crc ? 7'd2 : 7'd0);
						lstate <= LK_BODY;
					end else if (!o_fifo_rd && remain == 7'h00) begin
						o_fifo_rd <= 1'b0;
					end
				end
				LK_BODY: begin
					if (fetch_pend) begin
						o_mod_valid <= 1'b1;
						o_mod_byte <= i_fifo_data;
						remain <= remain - 7'd1;
					end else if (!o_fifo_rd) begin
						if (remain != 7'h00)
							o_fifo_rd <= 1'b1;
						else
							lstate <= auto_crc ? LK_FCS_LO : LK_DONE;
					end
				end
				LK_FCS_LO: begin
					o_mod_valid <= 1'b1;
					o_mod_byte <= crc[7:0];
					lstate <= LK_FCS_HI;
				end
				LK_FCS_HI: begin
					o_mod_valid <= 1'b1;
					o_mod_byte <= crc[15:8];
					lstate <= LK_DONE;
				end
				LK_DONE: begin
					sfd_level <= 1'b0;
				end
				default: lstate <= LK_WAIT_SFD;
			endcase
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			done_tgl <= 1'b0;
			sfd_tgl <= 1'b0;
		end else if (tx_run_link) begin
			if (lstate == LK_WAIT_SFD && i_sfd_sent)
				sfd_tgl <= ~sfd_tgl;
			if ((lstate == LK_FCS_HI)
					|| (lstate == LK_BODY && !auto_crc && !fetch_pend && !o_fifo_rd
					&& remain == 7'h00))
				done_tgl <= ~done_tgl;
		end
	end

	assign o_mod_alt = alt_link;
endmodule // radio_tx_framing_rx_enable_ctrl

// *** verif/radio_tx_monitor.sv ***
// Concurrent checks on the system-clock side of the framer.
// Assumes it is bound into the top module; link-side logic is judged by the bench.
module radio_tx_monitor #(
	parameter int TURNAROUND_CYC = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_strobe_receive_on,
	input wire logic i_strobe_radio_off,
	input wire logic i_strobe_transmit_on,
	input wire logic i_strobe_transmit_if_clear,
	input wire logic i_strobe_rx_mask_bit_set,
	input wire logic i_strobe_rx_mask_bit_clear,
	input wire logic i_rx_mask_set_on_transmit,
	input wire logic [6:0] i_tx_power_level,
	input wire logic i_tx_power_wr,
	input wire logic i_symbol_tick,
	input wire logic [15:0] o_rx_enable_mask,
	input wire logic o_rx_on,
	input wire logic o_tx_active,
	input wire logic o_preamble_start,
	input wire logic o_signal_strength_valid,
	input wire logic o_cca,
	input wire logic o_sfd_evt,
	input wire logic [6:0] o_tx_power_level
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	int wait_cnt;
	int tick_cnt;
	// ------
	// Helpers
	// ------
	// A fresh transmit request restarts the count
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_strobe_radio_off || o_preamble_start) begin
			wait_cnt <= 0;
		end else if (i_strobe_transmit_on || (i_strobe_transmit_if_clear && o_cca)) begin
			wait_cnt <= 1;
		end else if (wait_cnt != 0) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !o_rx_on) begin
			tick_cnt <= 0;
		end else if (i_symbol_tick && tick_cnt < 8) begin
			tick_cnt <= tick_cnt + 1;
		end
	end
	sequence s_tx_taken;
		i_strobe_transmit_on && !i_strobe_radio_off;
	endsequence
	// ------
	// Assertions
	// ------
	a_rx_on_bit: assert property (i_strobe_receive_on && !i_strobe_radio_off
		|=> o_rx_enable_mask[15]) else $error("receive-on left bit 15 clear");
	a_off_clears: assert property (i_strobe_radio_off
		|=> o_rx_enable_mask == 16'h0000 && !o_tx_active) else $error("radio-off left state");
	a_mask_set_13: assert property (i_strobe_rx_mask_bit_set && !i_strobe_rx_mask_bit_clear
		&& !i_strobe_radio_off |=> o_rx_enable_mask[13]) else $error("bit 13 not set");
	a_mask_clr_13: assert property (i_strobe_rx_mask_bit_clear
		|=> !o_rx_enable_mask[13]) else $error("bit 13 not cleared");
	a_tx_bit_14: assert property (s_tx_taken ##0 i_rx_mask_set_on_transmit
		|=> o_rx_enable_mask[14]) else $error("transmit-on left bit 14 clear");
	a_rx_on_level: assert property (o_rx_on == (o_rx_enable_mask != 16'h0000))
		else $error("receiver enable disagrees with mask");
	a_power_hold: assert property (i_tx_power_wr
		|=> o_tx_power_level == $past(i_tx_power_level)) else $error("power not taken");
	a_turnaround: assert property (o_preamble_start |-> wait_cnt == TURNAROUND_CYC + 1)
		else $error("preamble start at wrong cycle");
	a_valid_after: assert property ($rose(o_signal_strength_valid) |-> tick_cnt == 8)
		else $error("strength valid too early");
	a_sfd_pulse: assert property (o_sfd_evt |=> !o_sfd_evt)
		else $error("start event longer than one cycle");
endmodule // radio_tx_monitor

bind radio_tx_framing_rx_enable_ctrl radio_tx_monitor #(.TURNAROUND_CYC(TURNAROUND_CYC)) u_mon (
	.i_sys_clk, .i_rst, .i_strobe_receive_on, .i_strobe_radio_off, .i_strobe_transmit_on,
	.i_strobe_transmit_if_clear, .i_strobe_rx_mask_bit_set, .i_strobe_rx_mask_bit_clear,
	.i_rx_mask_set_on_transmit, .i_tx_power_level, .i_tx_power_wr, .i_symbol_tick,
	.o_rx_enable_mask, .o_rx_on, .o_tx_active, .o_preamble_start, .o_signal_strength_valid,
	.o_cca, .o_sfd_evt, .o_tx_power_level
);

// *** verif/tx_fifo_model.sv ***
// Far side of the framer: transmit FIFO and delimiter source.
// Assumes the bench loads mem before a frame and calls send_sfd.
module tx_fifo_model (
	input wire logic i_link_clk,
	input wire logic i_fifo_rd,
	output logic [7:0] o_fifo_data,
	output logic o_sfd_sent
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:15];
	int rd_ptr = 0;
	initial begin
		o_fifo_data = 8'h00;
		o_sfd_sent = 1'b0;
	end
	// Line is not held between fetches, so stale data passes only at an even cycle offset
	always @(posedge i_link_clk) begin
		if (i_fifo_rd) begin
			o_fifo_data <= mem[rd_ptr];
			rd_ptr <= rd_ptr + 1;
		end else begin
			o_fifo_data <= ~o_fifo_data;
		end
	end
	task send_sfd();
		@(posedge i_link_clk);
		rd_ptr <= 0;
		o_sfd_sent <= 1'b1;
		@(posedge i_link_clk);
		o_sfd_sent <= 1'b0;
	endtask
endmodule // tx_fifo_model

// *** verif/tb.sv ***
// Self-checking bench for the framer and receive enable control.
// Assumes the FIFO model as far side and a shortened turnaround.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TA = 20;
	logic i_sys_clk = 1'b0, i_link_clk = 1'b0, i_rst = 1'b1, i_link_rst = 1'b1;
	logic i_strobe_receive_on = 1'b0, i_strobe_radio_off = 1'b0, i_strobe_transmit_on = 1'b0;
	logic i_strobe_transmit_if_clear = 1'b0, i_strobe_sample_clear_channel = 1'b0;
	logic i_strobe_rx_mask_bit_set = 1'b0, i_strobe_rx_mask_bit_clear = 1'b0, i_mask_instr = 1'b0;
	radio_tx_pkg::mask_op_t i_mask_op = radio_tx_pkg::MASK_WRITE;
	logic [15:0] i_mask_data = 16'h0000;
	logic i_auto_checksum_en = 1'b1, i_rx_mask_set_on_transmit = 1'b1, i_alt_modulation_sel = 1'b0;
	logic i_tx_power_wr = 1'b0, i_rssi_sample = 1'b0, i_symbol_tick = 1'b0, i_sfd_sent;
	logic [6:0] i_tx_power_level = 7'h03;
	logic [7:0] i_gpio_cfg = 8'h2A, i_cca_threshold = 8'h40, i_rssi = 8'h10, i_fifo_data;
	logic [1:0] i_cca_mode = 2'h1;
	logic o_fifo_rd, o_mod_valid, o_mod_alt, o_rx_on, o_tx_active, o_preamble_start;
	logic o_signal_strength_valid, o_cca, o_sampled_cca, o_sfd_evt, o_tx_frame_complete_evt;
	logic o_gpio_sfd;
	logic [7:0] o_mod_byte;
	logic [15:0] o_rx_enable_mask;
	logic [6:0] o_tx_power_level;
	logic [7:0] sent [$];
	int fail_count = 0, total_checks = 0, cyc = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;
	always #6 i_link_clk = ~i_link_clk;

	radio_tx_framing_rx_enable_ctrl #(.TURNAROUND_CYC(TA)) u_dut (
		.i_sys_clk, .i_rst, .i_link_clk, .i_link_rst, .i_strobe_receive_on, .i_strobe_radio_off,
		.i_strobe_transmit_on, .i_strobe_transmit_if_clear, .i_strobe_sample_clear_channel,
		.i_strobe_rx_mask_bit_set, .i_strobe_rx_mask_bit_clear, .i_mask_instr, .i_mask_op,
		.i_mask_data, .i_auto_checksum_en, .i_rx_mask_set_on_transmit, .i_alt_modulation_sel,
		.i_tx_power_level, .i_tx_power_wr, .i_gpio_cfg, .i_cca_threshold, .i_cca_mode,
		.i_rssi_sample, .i_rssi, .i_symbol_tick, .o_fifo_rd, .i_fifo_data, .o_mod_valid,
		.o_mod_byte, .o_mod_alt, .i_sfd_sent, .o_rx_enable_mask, .o_rx_on, .o_tx_active,
		.o_preamble_start, .o_signal_strength_valid, .o_cca, .o_sampled_cca, .o_sfd_evt,
		.o_tx_frame_complete_evt, .o_gpio_sfd, .o_tx_power_level
	);
	tx_fifo_model u_far (
		.i_link_clk, .i_fifo_rd(o_fifo_rd), .o_fifo_data(i_fifo_data), .o_sfd_sent(i_sfd_sent)
	);

	// ------
	// Helpers
	// ------
	always @(posedge i_link_clk) begin
		if (o_mod_valid) begin
			sent.push_back(o_mod_byte);
		end
	end
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task instr(input radio_tx_pkg::mask_op_t op, input logic [15:0] d, input logic [15:0] e);
		i_mask_op = op;
		i_mask_data = d;
		pulse(i_mask_instr);
		check(o_rx_enable_mask, e);
		// Let an edge pass so back-to-back calls never re-raise in one step
		tick(1);
	endtask
	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		end
		return c;
	endfunction
	task final_report();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ------
	// Scenarios
	// ------
	task test_mask();
		check(o_tx_power_level, 7'h32);
		instr(radio_tx_pkg::MASK_WRITE, 16'h00f0, 16'h00f0);
		check(o_rx_on, 16'h0001);
		instr(radio_tx_pkg::MASK_OR, 16'h0003, 16'h00f3);
		instr(radio_tx_pkg::MASK_AND, 16'h0f0f, 16'h0003);
		instr(radio_tx_pkg::MASK_BIT_SET, 16'h0009, 16'h0203);
		instr(radio_tx_pkg::MASK_BIT_CLEAR, 16'h0000, 16'h0202);
		pulse(i_strobe_rx_mask_bit_set);
		check(o_rx_enable_mask, 16'h2202);
		pulse(i_strobe_rx_mask_bit_clear);
		check(o_rx_enable_mask, 16'h0202);
		pulse(i_strobe_receive_on);
		check(o_rx_enable_mask, 16'h8202);
		instr(radio_tx_pkg::MASK_WRITE, 16'h0000, 16'h0000);
		check(o_rx_on, 16'h0000);
		pulse(i_strobe_receive_on);
		pulse(i_strobe_radio_off);
		check(o_rx_enable_mask, 16'h0000);
		pulse(i_tx_power_wr);
		check(o_tx_power_level, 7'h03);
		$display("mask test done");
	endtask
	task automatic test_tx(input logic ac);
		logic [15:0] c;
		logic [7:0] e [5];
		int n;
		c = crc_b(crc_b(16'h0000, 8'ha5), 8'h3c);
		e = '{8'h04, 8'ha5, 8'h3c, c[7:0], c[15:8]};
		// Host writes the checksum in both modes, low byte inverted when the device appends its own; length >= 2
		for (int i = 0; i < 16; i++) begin
			u_far.mem[i] = (i < 5) ? e[i] : 8'h00;
		end
		if (ac) begin
			u_far.mem[3] = ~c[7:0];
		end
		i_auto_checksum_en = ac;
		i_alt_modulation_sel = !ac;
		i_gpio_cfg = ac ? 8'h2A : 8'h00;
		sent.delete();
		pulse(i_strobe_transmit_on);
		n = 1;
		while (!o_preamble_start && n < 100) begin
			tick(1);
			n++;
		end
		check(16'(n), 16'(TA + 1));
		check(o_rx_enable_mask[14], 16'h0001);
		u_far.send_sfd();
		n = 0;
		while (!o_sfd_evt && n < 20) begin
			tick(1);
			n++;
		end
		check(o_sfd_evt, 16'h0001);
		check(o_gpio_sfd, ac);
		n = 0;
		while (!o_tx_frame_complete_evt && n < 200) begin
			tick(1);
			n++;
		end
		check(o_tx_frame_complete_evt, 16'h0001);
		check(16'(sent.size()), 16'h0005);
		for (int i = 0; i < 5; i++) begin
			check(sent[i], e[i]);
		end
		check(o_mod_alt, !ac);
		pulse(i_strobe_radio_off);
		check(o_tx_active, 16'h0000);
		$display("frame test done");
	endtask
	task test_cca();
		pulse(i_strobe_receive_on);
		// Symbols only count once calibration is over
		tick(TA + 2);
		repeat (7) begin
			pulse(i_symbol_tick);
			tick(1);
		end
		check(o_signal_strength_valid, 16'h0000);
		pulse(i_symbol_tick);
		tick(3);
		check(o_signal_strength_valid, 16'h0001);
		check(o_cca, 16'h0000);
		tick(1);
		check(o_cca, 16'h0001);
		pulse(i_strobe_sample_clear_channel);
		check(o_sampled_cca, 16'h0001);
		i_rssi = 8'h50;
		pulse(i_rssi_sample);
		tick(1);
		check(o_cca, 16'h0000);
		check(o_sampled_cca, 16'h0001);
		// Busy channel: a conditional transmit is refused
		pulse(i_strobe_transmit_if_clear);
		check(o_sampled_cca, 16'h0000);
		tick(TA + 5);
		check(o_tx_active, 16'h0000);
		pulse(i_strobe_radio_off);
		$display("clear channel test done");
	endtask

	initial begin
		tick(3);
		i_rst = 1'b0;
		i_link_rst = 1'b0;
		test_mask();
		test_tx(1'b1);
		test_tx(1'b0);
		test_cca();
		final_report();
	end
endmodule // tb
